// ===== srdsc_pkg.sv
// Constants and carrier types for the receive drop statistics classifier
package srdsc_pkg;
    localparam int          LEN_W        = 14;
    localparam int          PORT_W       = 3;
    localparam int          TOF_W        = 4;
    localparam int          ADDR_W       = 12;
    localparam int          NCNT         = 19;
    // Counter indices
    localparam int          IDX_FRAG     = 0;
    localparam int          IDX_BOF      = 1;
    localparam int          IDX_PMASK    = 2;
    localparam int          IDX_TOF      = 3;
    localparam int          IDX_ALE      = 4;
    localparam int          IDX_OVR      = 5;
    localparam int          IDX_RATE     = 6;
    localparam int          IDX_VLAN     = 7;
    localparam int          IDX_DASA     = 8;
    localparam int          IDX_BLOCK    = 9;
    localparam int          IDX_SECURE   = 10;
    localparam int          IDX_AUTH     = 11;
    localparam int          IDX_UNK_UNI  = 12;
    localparam int          IDX_UNI_B    = 13;
    localparam int          IDX_UNK_MLT  = 14;
    localparam int          IDX_MLT_B    = 15;
    localparam int          IDX_UNK_BRD  = 16;
    localparam int          IDX_BRD_B    = 17;
    localparam int          IDX_RXOCT    = 18;
    // Register byte addresses
    localparam logic [11:0] A_CTRL       = 12'h000;
    localparam logic [11:0] A_MAXLEN     = 12'h004;
    localparam logic [11:0] A_STATUS     = 12'h008;
    localparam logic [11:0] A_CNT_BASE   = 12'h040;
    localparam int          CTRL_AUTH    = 0;
    localparam int          ST_IRQ       = 0;
    localparam int          ST_BUSY      = 1;
    // Reset values and frame length limits
    localparam logic [13:0] MAXLEN_RST   = 14'h05ee;
    localparam logic [13:0] LEN_MIN_GOOD = 14'h0040;
    localparam logic [13:0] LEN_PMASK    = 14'h0020;
    localparam logic [13:0] LEN_SHORT    = 14'h0021;
    localparam logic [13:0] LEN_HOST_MIN = 14'h0011;
    localparam int          HIGH_BIT     = 31;
    localparam int          LOOKUP_GAP   = 8;

    typedef struct packed {
        logic              valid;
        logic [PORT_W-1:0] rx_port;
        logic [LEN_W-1:0]  len;
        logic              is_data;
        logic              addr_match;
        logic              da_mcast;
        logic              da_bcast;
        logic              odd_nibbles;
        logic              fcs_fail;
        logic              fcs_fail_trunc;
        logic              rx_symbol_error_pin;
        logic              fc_collision;
        logic              fifo_full_drop;
        logic              mask_zero;
        logic [TOF_W-1:0]  tof_drops;
        logic              rx_rate_drop;
        logic              tx_rate_pruned;
        logic              vlan_fail;
        logic              super_match;
        logic              da_eq_sa;
        logic              sa_known;
        logic              sa_secure;
        logic [PORT_W-1:0] sa_port;
        logic              da_super;
        logic              to_rx_port;
        logic              block_hit;
    } srdsc_frame_t;
endpackage

// ===== srdsc_classifier.sv
// Receive drop and unknown-source statistics classifier with AHB-Lite access
`timescale 1ns/1ns
// Overview of operation
// - Count short errored data frames as fragments
// - Ethernet ports count matched frames lost to FIFO
// - Host port FIFO drop counts frames of 17 bytes and over
// - Ethernet drops under 33 bytes skip FIFO counter
// - Zero-mask frames over 32 bytes count portmask drops
// - Top-of-FIFO adds one per dropping egress port
// - Zero-mask non-self, non-loop clean frames count lookup drop
// - Lookup rate exceeded aborts, zero mask, overrun count
// - Host ingress paced to avoid lookup overruns
// - Receive or transmit rate limiting counts rate drops
// - VLAN ingress failure without super match counts
// - DA equals unknown SA counts drop
// - Blocked source or destination entry counts drop
// - Secure entry owned elsewhere counts secure drop
// - Authorization mode drops unknown non-super frames
// - Unknown-source unicast frames and bytes counted
// - Unknown-source multicast data frames and bytes counted
// - Unknown-source broadcast data frames counted
// - Good frame bytes added to receive octets
// - Raw interrupt while any counter reaches 2^31
// - Odd nibbles failing truncated check are alignment errors
module srdsc_classifier
    import srdsc_pkg::*;
#(
    parameter int HOST_PORT = 0,
    parameter int GAP       = LOOKUP_GAP
) (
    input  wire  logic         core_clk,
    input  wire  logic         resetn,
    input  wire  srdsc_frame_t frm_in,
    input  wire  logic         hsel,
    input  wire  logic [31:0]  haddr,
    input  wire  logic [1:0]   htrans,
    input  wire  logic         hwrite,
    input  wire  logic [2:0]   hsize,
    input  wire  logic [31:0]  hwdata,
    input  wire  logic         hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    output logic               stat_module_irq_raw,
    output logic               host_ingress_hold,
    output logic               lookup_abort
);
    localparam int GAP_W = 8;

    typedef struct packed {
        logic [NCNT-1:0][31:0] cnt;
        logic                  authorization_mode_en;
        logic [LEN_W-1:0]      port_rx_max_frame_len;
        logic                  dp_wr;
        logic [ADDR_W-1:0]     dp_addr;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  irq;
        logic [GAP_W-1:0]      busy;
        logic                  hold;
        logic                  abort;
    } srdsc_state_t;

    srdsc_state_t s_ff;
    srdsc_state_t nxt_s;

    generate
        if (GAP < 1 || GAP > 255 || HOST_PORT < 0 || HOST_PORT >= (1 << PORT_W)) begin : g_chk
            $error("srdsc_classifier: GAP or HOST_PORT out of range");
        end
    endgenerate

    // Counter index for an address, NCNT when not a counter
    function automatic int cnt_idx(input logic [ADDR_W-1:0] a);
        int r;
        r = NCNT;
        if (a >= A_CNT_BASE && a[1:0] == 2'h0 && ((a - A_CNT_BASE) >> 2) < NCNT) begin
            r = int'((a - A_CNT_BASE) >> 2);
        end
        return r;
    endfunction

    function automatic logic is_byte_cnt(input int i);
        return i == IDX_UNI_B || i == IDX_MLT_B || i == IDX_BRD_B || i == IDX_RXOCT;
    endfunction

    logic                        e_crc;
    logic                        e_aln;
    logic                        clean;
    logic                        is_host;
    logic                        host_short;
    logic                        ovr;
    logic                        mz;
    logic                        in_win;
    logic                        good;
    logic                        unk;
    logic                        ok_m;
    logic                        acc;
    logic [NCNT-1:0]             hit;
    logic [NCNT-1:0][31:0]       inc;
    logic [NCNT-1:0][31:0]       dec;
    logic [ADDR_W-1:0]           a_in;

    always_comb begin
        nxt_s = s_ff;
        a_in = haddr[ADDR_W-1:0];
        // CRC versus alignment split by nibble parity
        e_crc = frm_in.fcs_fail && !frm_in.odd_nibbles;
        e_aln = frm_in.odd_nibbles && frm_in.fcs_fail_trunc;
        clean = !(e_crc || e_aln || frm_in.rx_symbol_error_pin);
        is_host = frm_in.rx_port == PORT_W'(HOST_PORT);
        host_short = is_host && frm_in.len < LEN_SHORT;
        // A lookup still running means this one cannot be served
        ovr = frm_in.valid && !is_host && s_ff.busy != '0;
        mz = frm_in.mask_zero || ovr;
        in_win = frm_in.len >= LEN_MIN_GOOD && frm_in.len <= s_ff.port_rx_max_frame_len;
        ok_m = clean && frm_in.addr_match;
        good = ok_m && in_win;
        unk = good && !frm_in.sa_known;

        hit = '0;
        hit[IDX_FRAG] = frm_in.is_data && frm_in.len < LEN_MIN_GOOD && !clean
                        && !frm_in.fc_collision;
        hit[IDX_PMASK] = frm_in.len > LEN_PMASK && mz;
        hit[IDX_TOF] = ok_m && frm_in.tof_drops != '0;
        hit[IDX_ALE] = ok_m && !frm_in.da_eq_sa && !frm_in.to_rx_port && mz;
        hit[IDX_OVR] = ovr && frm_in.addr_match;
        hit[IDX_RATE] = ok_m && (frm_in.rx_rate_drop || frm_in.tx_rate_pruned);
        hit[IDX_VLAN] = ok_m && mz && frm_in.vlan_fail && !frm_in.super_match;
        hit[IDX_DASA] = ok_m && mz && frm_in.da_eq_sa && !frm_in.sa_known;
        hit[IDX_BLOCK] = ok_m && mz && frm_in.block_hit;
        hit[IDX_SECURE] = ok_m && mz && frm_in.sa_known && frm_in.sa_secure
                          && frm_in.sa_port != frm_in.rx_port;
        hit[IDX_AUTH] = ok_m && mz && s_ff.authorization_mode_en && !frm_in.da_eq_sa
                        && !frm_in.sa_known && !frm_in.da_super;
        hit[IDX_UNK_UNI] = unk && !frm_in.da_mcast && !frm_in.da_bcast;
        hit[IDX_UNI_B] = hit[IDX_UNK_UNI];
        hit[IDX_UNK_MLT] = unk && frm_in.is_data && frm_in.da_mcast;
        hit[IDX_MLT_B] = hit[IDX_UNK_MLT];
        hit[IDX_UNK_BRD] = unk && frm_in.is_data && frm_in.da_bcast;
        hit[IDX_BRD_B] = hit[IDX_UNK_BRD];
        hit[IDX_RXOCT] = good;
        // Host frames below 33 bytes show only in the FIFO drop count
        if (!frm_in.valid || host_short) begin
            hit = '0;
        end
        hit[IDX_BOF] = frm_in.valid && frm_in.fifo_full_drop
                       && (is_host ? frm_in.len >= LEN_HOST_MIN
                                   : frm_in.addr_match && frm_in.len >= LEN_SHORT);

        // Software write to a counter subtracts the written value
        for (int i = 0; i < NCNT; i++) begin
            if (!hit[i]) begin
                inc[i] = '0;
            end else if (is_byte_cnt(i)) begin
                inc[i] = 32'(frm_in.len);
            end else if (i == IDX_TOF) begin
                inc[i] = 32'(frm_in.tof_drops);
            end else begin
                inc[i] = 32'h0000_0001;
            end
            dec[i] = (s_ff.dp_wr && cnt_idx(s_ff.dp_addr) == i) ? hwdata : 32'h0;
            nxt_s.cnt[i] = s_ff.cnt[i] + inc[i] - dec[i];
        end

        if (s_ff.dp_wr && s_ff.dp_addr == A_CTRL) begin
            nxt_s.authorization_mode_en = hwdata[CTRL_AUTH];
        end
        if (s_ff.dp_wr && s_ff.dp_addr == A_MAXLEN) begin
            nxt_s.port_rx_max_frame_len = hwdata[LEN_W-1:0];
        end

        // AHB-Lite: zero wait state, read data prepared in address phase
        acc = hsel && htrans[1] && hready;
        nxt_s.dp_wr = acc && hwrite;
        nxt_s.dp_addr = acc ? a_in : s_ff.dp_addr;
        nxt_s.ready = 1'b1;
        nxt_s.rdata = 32'h0;
        if (acc && !hwrite) begin
            if (a_in == A_CTRL) begin
                nxt_s.rdata[CTRL_AUTH] = s_ff.authorization_mode_en;
            end else if (a_in == A_MAXLEN) begin
                nxt_s.rdata[LEN_W-1:0] = s_ff.port_rx_max_frame_len;
            end else if (a_in == A_STATUS) begin
                nxt_s.rdata[ST_IRQ] = s_ff.irq;
                nxt_s.rdata[ST_BUSY] = s_ff.busy != '0;
            end else if (cnt_idx(a_in) < NCNT) begin
                nxt_s.rdata = s_ff.cnt[cnt_idx(a_in)];
            end
        end

        // Lookup slot timing; overrun frames do not restart it
        if (frm_in.valid && !ovr) begin
            nxt_s.busy = GAP_W'(GAP);
        end else if (s_ff.busy != '0) begin
            nxt_s.busy = s_ff.busy - GAP_W'(1);
        end
        // Hold the host port while a lookup is pending
        nxt_s.hold = nxt_s.busy > GAP_W'(1);
        nxt_s.abort = ovr;

        nxt_s.irq = 1'b0;
        for (int i = 0; i < NCNT; i++) begin
            nxt_s.irq = nxt_s.irq | nxt_s.cnt[i][HIGH_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_ff <= '0;
            s_ff.port_rx_max_frame_len <= MAXLEN_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hrdata = s_ff.rdata;
    assign hreadyout = s_ff.ready;
    assign hresp = 1'b0;
    assign stat_module_irq_raw = s_ff.irq;
    assign host_ingress_hold = s_ff.hold;
    assign lookup_abort = s_ff.abort;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic no_wr;
    assign no_wr = !s_ff.dp_wr;

    sequence frag_frame;
        frm_in.valid && frm_in.is_data && frm_in.len < LEN_MIN_GOOD
        && frm_in.rx_symbol_error_pin && !frm_in.fc_collision && !is_host;
    endsequence

    chk_frag_counts: assert property (frag_frame and no_wr
        |=> s_ff.cnt[IDX_FRAG] == $past(s_ff.cnt[IDX_FRAG]) + 32'h1)
        else $error("fragment not counted");
    chk_host_short: assert property (frm_in.valid && is_host && frm_in.len < LEN_SHORT
        && no_wr |=> s_ff.cnt[IDX_RXOCT] == $past(s_ff.cnt[IDX_RXOCT]))
        else $error("short host frame reached another counter");
    chk_eth_short_bof: assert property (frm_in.valid && !is_host && frm_in.len < LEN_SHORT
        && no_wr |=> s_ff.cnt[IDX_BOF] == $past(s_ff.cnt[IDX_BOF]))
        else $error("short ethernet drop in fifo counter");
    chk_tof_adds: assert property (hit[IDX_TOF] && no_wr
        |=> s_ff.cnt[IDX_TOF] == $past(s_ff.cnt[IDX_TOF]) + 32'($past(frm_in.tof_drops)))
        else $error("top of fifo count not per port");
    chk_ovr_abort: assert property (frm_in.valid && !is_host && s_ff.busy != '0
        |=> lookup_abort ##1 !lookup_abort || $past(ovr))
        else $error("overrun not aborted");
    chk_host_paced: assert property (host_ingress_hold |-> s_ff.busy > GAP_W'(1))
        else $error("host hold without pending lookup");
    chk_octets_len: assert property (frm_in.valid && good && !host_short && no_wr
        |=> s_ff.cnt[IDX_RXOCT] - $past(s_ff.cnt[IDX_RXOCT]) == 32'($past(frm_in.len)))
        else $error("octets not added");
    chk_irq_high: assert property (s_ff.cnt[IDX_FRAG][HIGH_BIT] |-> stat_module_irq_raw)
        else $error("irq missing at high counter");
    chk_bus_ready: assert property (acc |=> hreadyout && !hresp)
        else $error("bus not zero wait okay");

    // Clean matched frame that reaches the lookup counters
    sequence clean_matched;
        frm_in.valid && ok_m && !host_short && no_wr;
    endsequence

    // Same frame, also left with no destination
    sequence zero_mask_hit;
        frm_in.valid && ok_m && mz && !host_short && no_wr;
    endsequence

    chk_bof_eth: assert property (frm_in.valid && !is_host && frm_in.fifo_full_drop
        && frm_in.addr_match && frm_in.len >= LEN_SHORT && no_wr
        |=> s_ff.cnt[IDX_BOF] == $past(s_ff.cnt[IDX_BOF]) + 32'h1)
        else $error("fifo drop not counted");
    chk_pmask_count: assert property (frm_in.valid && frm_in.len > LEN_PMASK
        && frm_in.mask_zero && no_wr
        |=> s_ff.cnt[IDX_PMASK] == $past(s_ff.cnt[IDX_PMASK]) + 32'h1)
        else $error("portmask drop not counted");
    chk_ale_count: assert property (zero_mask_hit ##0 (!frm_in.da_eq_sa
        && !frm_in.to_rx_port) |=> s_ff.cnt[IDX_ALE] == $past(s_ff.cnt[IDX_ALE]) + 32'h1)
        else $error("lookup drop not counted");
    chk_ovr_count: assert property (frm_in.valid && ovr && frm_in.addr_match && no_wr
        |=> s_ff.cnt[IDX_OVR] == $past(s_ff.cnt[IDX_OVR]) + 32'h1)
        else $error("overrun not counted");
    chk_rate_count: assert property (clean_matched ##0 frm_in.rx_rate_drop
        |=> s_ff.cnt[IDX_RATE] == $past(s_ff.cnt[IDX_RATE]) + 32'h1)
        else $error("rate drop not counted");
    chk_vlan_count: assert property (zero_mask_hit ##0 (frm_in.vlan_fail
        && !frm_in.super_match) |=> s_ff.cnt[IDX_VLAN] == $past(s_ff.cnt[IDX_VLAN]) + 32'h1)
        else $error("vlan drop not counted");
    chk_dasa_count: assert property (zero_mask_hit ##0 (frm_in.da_eq_sa
        && !frm_in.sa_known) |=> s_ff.cnt[IDX_DASA] == $past(s_ff.cnt[IDX_DASA]) + 32'h1)
        else $error("da equals sa drop not counted");
    chk_block_count: assert property (zero_mask_hit ##0 frm_in.block_hit
        |=> s_ff.cnt[IDX_BLOCK] == $past(s_ff.cnt[IDX_BLOCK]) + 32'h1)
        else $error("blocked drop not counted");
    chk_secure_count: assert property (zero_mask_hit ##0 (frm_in.sa_known
        && frm_in.sa_secure && frm_in.sa_port != frm_in.rx_port)
        |=> s_ff.cnt[IDX_SECURE] == $past(s_ff.cnt[IDX_SECURE]) + 32'h1)
        else $error("secure drop not counted");
    chk_auth_count: assert property (zero_mask_hit ##0 (s_ff.authorization_mode_en
        && !frm_in.da_eq_sa && !frm_in.sa_known && !frm_in.da_super)
        |=> s_ff.cnt[IDX_AUTH] == $past(s_ff.cnt[IDX_AUTH]) + 32'h1)
        else $error("auth drop not counted");
    chk_unk_bytes: assert property (clean_matched ##0 (in_win && !frm_in.sa_known
        && !frm_in.da_mcast && !frm_in.da_bcast)
        |=> s_ff.cnt[IDX_UNI_B] - $past(s_ff.cnt[IDX_UNI_B]) == 32'($past(frm_in.len)))
        else $error("unknown unicast bytes not added");
    chk_align_pass: assert property (frm_in.valid && frm_in.odd_nibbles
        && !frm_in.fcs_fail_trunc && !frm_in.rx_symbol_error_pin |-> clean)
        else $error("odd frame passing truncated check flagged");
    chk_irq_octets: assert property (s_ff.cnt[IDX_RXOCT][HIGH_BIT] |-> stat_module_irq_raw)
        else $error("irq missing at high octet counter");
    // Bus decrement must not be lost when no frame hits the counter
    chk_cnt_sub: assert property (s_ff.dp_wr && cnt_idx(s_ff.dp_addr) == IDX_FRAG
        && !hit[IDX_FRAG] |=> s_ff.cnt[IDX_FRAG] == $past(s_ff.cnt[IDX_FRAG]) - $past(hwdata))
        else $error("counter decrement lost");
endmodule

// ===== srdsc_mac_model.sv
// Behavioural model of the port receive MAC and lookup front end
`timescale 1ns/1ns
module srdsc_mac_model
    import srdsc_pkg::*;
#(
    parameter int HOST_PORT = 0
) (
    input  wire logic    core_clk,
    input  wire logic    host_ingress_hold,
    output srdsc_frame_t frm_out
);
    initial frm_out = '0;

    // Sends n copies on consecutive cycles; n above one outruns the lookup on an Ethernet port
    task automatic send(input srdsc_frame_t fr, input int n);
        srdsc_frame_t idle;
        idle       = ~fr;
        idle.valid = 1'b0;
        while (int'(fr.rx_port) == HOST_PORT && host_ingress_hold !== 1'b0) begin
            @(posedge core_clk);
        end
        frm_out <= fr;
        repeat (n) @(posedge core_clk);
        // Stale fields inverted so reading them off-valid gets caught
        frm_out <= idle;
        @(posedge core_clk);
    endtask
endmodule

// ===== srdsc_classifier_tb.sv
// Self-checking testbench for the receive drop statistics classifier
`timescale 1ns/1ns
module srdsc_classifier_tb import srdsc_pkg::*;;
    logic         core_clk;
    logic         resetn;
    logic         hsel;
    logic         hwrite;
    logic [1:0]   htrans;
    logic [31:0]  haddr;
    logic [31:0]  hwdata;
    logic [31:0]  hrdata;
    logic [31:0]  rd;
    logic         hreadyout;
    logic         hresp;
    logic         irq;
    logic         hold;
    logic         abort;
    srdsc_frame_t frm;
    srdsc_frame_t f;
    logic [31:0]  wc [NCNT];
    int           n_mismatch;
    int           num_checks;
    localparam int TBL [9] = '{IDX_RATE, IDX_RATE, IDX_VLAN, IDX_DASA, IDX_BLOCK,
                               IDX_SECURE, -1, IDX_AUTH, -1};

    srdsc_classifier #(.HOST_PORT(0), .GAP(LOOKUP_GAP)) i_srdsc_classifier (
        .core_clk(core_clk), .resetn(resetn), .frm_in(frm), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stat_module_irq_raw(irq),
        .host_ingress_hold(hold), .lookup_abort(abort));
    srdsc_mac_model #(.HOST_PORT(0)) p_mac (
        .core_clk(core_clk), .host_ingress_hold(hold), .frm_out(frm));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // Hready is sampled before moving on, so wait states would be honoured
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] want);
        ahb(1'b0, a, 32'h0);
        chk(rd, want);
    endtask

    task automatic check_all();
        for (int i = 0; i < NCNT; i++) begin
            rdchk(A_CNT_BASE + 12'(4 * i), wc[i]);
        end
    endtask

    function automatic srdsc_frame_t base();
        return '{valid: 1'b1, rx_port: 3'h1, len: 14'h064, is_data: 1'b1, addr_match: 1'b1,
                 sa_known: 1'b1, sa_port: 3'h1, default: '0};
    endfunction

    task automatic fr(input int n);
        p_mac.send(f, n);
        repeat (LOOKUP_GAP + 4) @(posedge core_clk);
    endtask

    task automatic t_reset();
        rdchk(A_MAXLEN, {18'h0, MAXLEN_RST});
        rdchk(A_CTRL, 32'h0);
        rdchk(12'h100, 32'h0);
        check_all();
    endtask

    task automatic t_frag();
        for (int k = 0; k < 5; k++) begin
            f                     = base();
            f.len                 = (k == 4) ? LEN_MIN_GOOD : 14'h03f;
            f.addr_match          = 1'b0;
            f.fcs_fail            = (k < 2 || k == 4);
            f.fc_collision        = (k == 1);
            f.odd_nibbles         = (k == 2);
            f.fcs_fail_trunc      = (k == 2);
            f.rx_symbol_error_pin = (k == 3);
            fr(1);
            if (k == 0 || k == 2 || k == 3) wc[IDX_FRAG] += 1;
        end
        check_all();
    endtask

    task automatic t_fifo();
        for (int k = 0; k < 4; k++) begin
            f                = base();
            f.rx_port        = (k < 2) ? 3'h1 : 3'h0;
            f.len            = (k == 0) ? LEN_SHORT : (k == 1) ? LEN_PMASK : (k == 2) ? LEN_HOST_MIN : 14'h010;
            f.fifo_full_drop = 1'b1;
            fr(1);
            if (k == 0 || k == 2) wc[IDX_BOF] += 1;
        end
        check_all();
    endtask

    task automatic t_mask_tof();
        f           = base();
        f.len       = LEN_SHORT;
        f.mask_zero = 1'b1;
        fr(1);
        wc[IDX_PMASK] += 1;
        wc[IDX_ALE] += 1;
        f.len        = LEN_PMASK;
        f.to_rx_port = 1'b1;
        fr(1);
        f           = base();
        f.tof_drops = 4'h3;
        fr(1);
        wc[IDX_TOF] += 3;
        wc[IDX_RXOCT] += 32'h64;
        check_all();
    endtask

    task automatic t_overrun();
        f     = base();
        f.len = 14'h028;
        // Second copy lands on a busy lookup; abort pulses after that edge
        fork
            p_mac.send(f, 2);
        join_none
        @(posedge core_clk);
        #1;
        chk(32'(abort), 32'h0);
        @(posedge core_clk);
        #1;
        chk(32'(abort), 32'h1);
        @(posedge core_clk);
        #1;
        chk(32'(abort), 32'h0);
        repeat (LOOKUP_GAP + 4) @(posedge core_clk);
        wc[IDX_OVR] += 1;
        wc[IDX_PMASK] += 1;
        wc[IDX_ALE] += 1;
        // Host frames back to back must be paced, never overrun
        f.rx_port = 3'h0;
        f.len     = 14'h064;
        p_mac.send(f, 1);
        #1;
        chk(32'(hold), 32'h1);
        fr(1);
        wc[IDX_RXOCT] += 32'hc8;
        check_all();
    endtask

    task automatic t_drops();
        int idx;
        for (int k = 0; k < 9; k++) begin
            f                = base();
            f.len            = 14'h028;
            f.to_rx_port     = 1'b1;
            f.rx_rate_drop   = (k == 0);
            f.tx_rate_pruned = (k == 1);
            f.mask_zero      = (k != 1);
            f.vlan_fail      = (k == 2 || k == 6);
            f.super_match    = (k == 6);
            f.da_eq_sa       = (k == 3);
            f.sa_known       = (k < 7 && k != 3);
            f.block_hit      = (k == 4);
            f.sa_secure      = (k == 5);
            f.sa_port        = (k == 5) ? 3'h3 : 3'h1;
            f.da_super       = (k == 8);
            idx              = TBL[k];
            if (k == 7) ahb(1'b1, A_CTRL, 32'h1);
            fr(1);
            if (idx >= 0) wc[idx] += 1;
            if (k != 1) wc[IDX_PMASK] += 1;
        end
        ahb(1'b1, A_CTRL, 32'h0);
        check_all();
    endtask

    task automatic t_unknown();
        for (int k = 0; k < 4; k++) begin
            f          = base();
            f.sa_known = 1'b0;
            f.da_mcast = (k == 1);
            f.da_bcast = (k == 2);
            f.len      = (k == 0) ? LEN_MIN_GOOD : (k == 1) ? 14'h064 : MAXLEN_RST + 14'(k - 2);
            fr(1);
            if (k < 3) begin
                wc[IDX_UNK_UNI + 2 * k] += 1;
                wc[IDX_UNI_B + 2 * k] += 32'(f.len);
                wc[IDX_RXOCT] += 32'(f.len);
            end
        end
        check_all();
    endtask

    task automatic t_irq();
        ahb(1'b1, A_CNT_BASE, wc[IDX_FRAG] + 32'h8000_0000);
        wc[IDX_FRAG] = 32'h8000_0000;
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        rdchk(A_STATUS, 32'h1);
        ahb(1'b1, A_CNT_BASE, 32'h1);
        wc[IDX_FRAG] = 32'h7fff_ffff;
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        ahb(1'b1, A_CNT_BASE, 32'h7fff_ffff);
        wc[IDX_FRAG] = 32'h0;
        check_all();
    endtask

    initial begin
        resetn     = 1'b0;
        hsel       = 1'b0;
        hwrite     = 1'b0;
        htrans     = 2'h0;
        haddr      = 32'h0;
        hwdata     = 32'h0;
        n_mismatch = 0;
        num_checks = 0;
        foreach (wc[i]) wc[i] = 32'h0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_frag();
        t_fifo();
        t_mask_tof();
        t_overrun();
        t_drops();
        t_unknown();
        t_irq();
        end_of_test();
    end

    // About 730 cycles expected; some forty times that means a hang
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end
endmodule
